// File: i2cr_bus_master.sv
// Purpose: far-side bus master model
// Assumes: pulled-up lines, low pull only
// Notes:   waits on a stretched clock, bounded
module i2cr_bus_master (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  // clock waits that ran out, counted as mismatches by the bench
  int stalls = 0;
  initial {scl_low, sda_low} = 2'b00;
  task automatic half();
    repeat (20) @(posedge clk);
  endtask
  task automatic start();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b1;
    half();
  endtask
  task automatic put_bit(input logic b, output logic seen);
    sda_low <= !b;
    half();
    scl_low <= 1'b0;
    // a held clock is waited out
    for (int n = 0; n < 5000 && scl !== 1'b1; n++) @(posedge clk);
    if (scl !== 1'b1) stalls++;
    half();
    seen = sda;
    scl_low <= 1'b1;
    half();
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic let_go();
    scl_low <= 1'b0;
  endtask
  task automatic stop();
    scl_low <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b0;
    half();
    sda_low <= 1'b0;
    half();
  endtask
endmodule

// File: i2cr_pkg.sv
// Purpose: shared constants of the two-wire bus status, clock and address block
// Assumes: 8-bit register port, 3-bit register index
// Notes:   offsets are register indices on the plain register port
package i2cr_pkg;

  // ==========================================================
  // register offsets
  localparam logic [2:0] OFF_CONTROL     = 3'h0;
  localparam logic [2:0] OFF_STATUS_ONE  = 3'h1;
  localparam logic [2:0] OFF_STATUS_TWO  = 3'h2;
  localparam logic [2:0] OFF_CLOCK_SET   = 3'h3;
  localparam logic [2:0] OFF_OWN_LOW     = 3'h4;
  localparam logic [2:0] OFF_OWN_HIGH    = 3'h5;
  localparam logic [2:0] OFF_BYTE_BUFFER = 3'h6;

  // ==========================================================
  // reset values
  localparam logic [7:0] CONTROL_RST     = 8'h00;
  localparam logic [7:0] CLOCK_SET_RST   = 8'h00;
  localparam logic [7:0] OWN_LOW_RST     = 8'h00;
  localparam logic [7:0] OWN_HIGH_RST    = 8'h40;
  localparam logic [7:0] BYTE_BUFFER_RST = 8'h00;

  // ==========================================================
  // control register bit positions
  localparam int CTL_PE    = 5;
  localparam int CTL_GENERAL_CALL_ENABLE  = 4;
  localparam int CTL_START = 3;
  localparam int CTL_ACK   = 2;
  localparam int CTL_STOP  = 1;
  localparam int CTL_ITE   = 0;

  // ==========================================================
  // clock register and own-address fields
  localparam int CLK_SPEED_BIT = 7;
  localparam int OWN_FR_HI     = 7;
  localparam int OWN_FR_LO     = 6;
  localparam int OWN_A9        = 2;
  localparam int OWN_A8        = 1;

  // ==========================================================
  // addresses and timing
  localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
  localparam logic [7:0] IGNORED_ADDR      = 8'h01;
  localparam logic [3:0] ACK_BIT_INDEX     = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT     = 4'h7;
  // cycles of the reference clock per divider step
  localparam int         STD_UNIT          = 8;
  localparam int         FAST_UNIT         = 2;

  // ==========================================================
  // bus clock generator states
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_START = 3'b001,
    M_LOW   = 3'b010,
    M_HIGH  = 3'b011,
    M_STOPA = 3'b100,
    M_STOPB = 3'b101,
    M_RSA   = 3'b110,
    M_RSB   = 3'b111
  } i2cr_mstate_t;

endpackage

// File: i2cr_properties.sv
// Purpose: port checks of i2cr_top
// Assumes: one REF_CLK domain, RST async high
// Notes:   shadows mirror software writes
module i2cr_properties
  import i2cr_pkg::*;
(
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic       WR_STB,
  input wire logic       RD_STB,
  input wire logic [7:0] RD_DATA,
  input wire logic       SCL_IN,
  input wire logic       SCL_OUT,
  input wire logic       SCL_OE,
  input wire logic       SDA_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE
);
  // ====
  // shadows
  logic       en, rd_q, sda_d;
  logic [2:0] a_q;
  logic [3:0] idle;
  logic [7:0] clk_sh, low_sh, high_sh;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      {en, rd_q, sda_d, a_q, idle} <= {3'b001, 3'h0, 4'hF};
      {clk_sh, low_sh, high_sh} <= {8'h00, 8'h00, 8'h40};
    end else begin
      rd_q <= RD_STB;
      a_q <= ADDR;
      sda_d <= SDA_IN;
      if (WR_STB && ADDR == OFF_CONTROL) en <= WR_DATA[CTL_PE];
      if (WR_STB && ADDR == OFF_CLOCK_SET) clk_sh <= WR_DATA;
      if (WR_STB && ADDR == OFF_OWN_LOW) low_sh <= WR_DATA;
      // frequency bits only follow a write while disabled
      if (WR_STB && ADDR == OFF_OWN_HIGH)
        high_sh <= {en ? high_sh[7:6] : WR_DATA[7:6], 3'h0, WR_DATA[2:1], 1'b0};
      if (SCL_IN && sda_d && !SDA_IN) idle <= 4'h0;
      else if (SCL_IN && !sda_d && SDA_IN) idle <= 4'h1;
      else if (idle != 4'h0 && idle != 4'hF) idle <= idle + 4'h1;
    end
  end
  // ====
  // properties
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_stat2_top: assert property (rd_q && a_q == OFF_STATUS_TWO |-> RD_DATA[7:5] == 3'h0)
    else $error("status two top bits set");
  a_clock_back: assert property (rd_q && a_q == OFF_CLOCK_SET |-> RD_DATA == clk_sh)
    else $error("clock setting readback wrong");
  a_own_low: assert property (rd_q && a_q == OFF_OWN_LOW |-> RD_DATA == low_sh)
    else $error("own address low readback wrong");
  a_own_high: assert property (rd_q && a_q == OFF_OWN_HIGH |-> RD_DATA == high_sh)
    else $error("own address high readback wrong");
  a_off_quiet: assert property (!en && !$past(en) |-> !SCL_OE && !SDA_OE)
    else $error("pins driven while disabled");
  a_bus_free: assert property (rd_q && a_q == OFF_STATUS_ONE && idle == 4'hF |-> !RD_DATA[4])
    else $error("bus active after stop");
  a_sda_steady: assert property ($changed(SDA_OE) |-> !SCL_IN)
    else $error("data line moved while clock high");
  a_drive_low: assert property (SCL_OUT == 1'b0 && SDA_OUT == 1'b0)
    else $error("pin driven high");
  c_ack: cover property ($rose(SDA_OE));
  c_hold: cover property ($rose(SCL_OE));
  c_busy: cover property (rd_q && a_q == OFF_STATUS_ONE && RD_DATA[4]);
endmodule
bind i2cr_top i2cr_properties u_i2cr_properties (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR),
  .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .SCL_IN(SCL_IN),
  .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE));

// File: i2cr_top.sv
// Purpose: status flags, clock setting, data and own address of a multimaster two-wire interface
// Assumes: 100 MHz REF_CLK, open-drain SCL/SDA split into in/out/enable
// Notes:   registers read back one cycle after the read strobe
module i2cr_top
  import i2cr_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WR_DATA,
  input  wire logic       WR_STB,
  input  wire logic       RD_STB,
  output logic      [7:0] RD_DATA,
  input  wire logic       SCL_IN,
  output logic            SCL_OUT,
  output logic            SCL_OE,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  output logic            IRQ
);

  // ==========================================================
  // half period of the generated bus clock
  function automatic logic [CNT_W-1:0] half_period(input logic [7:0] setting);
    logic [CNT_W-1:0] unit;
    unit = setting[CLK_SPEED_BIT] ? CNT_W'(FAST_UNIT) : CNT_W'(STD_UNIT);
    return CNT_W'((CNT_W'(setting[6:0]) + CNT_W'(1)) * unit);
  endfunction

  // ==========================================================
  // state
  logic         pe, gc_en, start_req, ack_en, stop_req, interrupt_enable_bit;
  logic         busy, byte_done, addr_matched, master_role, start_sent;
  logic         ack_fail, stop_seen, arb_lost, bus_err, general_call_seen_flag;
  logic [7:0]   clock_set, own_low, own_high, byte_buffer;
  logic         sr1_armed;
  logic         scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic         active, is_tx, s_addr, m_addr, ack_drive, nack_seen, slv_sel;
  logic [3:0]   bit_cnt;
  logic         start_fall;
  logic [7:0]   shreg;
  i2cr_mstate_t mst;
  logic [CNT_W-1:0] cnt;
  logic         next_scl_low, next_sda_low;

  // ==========================================================
  // register port decode
  logic wr_ctrl, wr_clk, wr_own_lo, wr_own_hi, wr_dr, rd_sr1, rd_sr2, rd_dr, dr_clear;
  assign wr_ctrl   = WR_STB && ADDR == OFF_CONTROL;
  assign wr_clk    = WR_STB && ADDR == OFF_CLOCK_SET;
  assign wr_own_lo = WR_STB && ADDR == OFF_OWN_LOW;
  assign wr_own_hi = WR_STB && ADDR == OFF_OWN_HIGH;
  assign wr_dr     = WR_STB && ADDR == OFF_BYTE_BUFFER;
  assign rd_sr1    = RD_STB && ADDR == OFF_STATUS_ONE;
  assign rd_sr2    = RD_STB && ADDR == OFF_STATUS_TWO;
  assign rd_dr     = RD_STB && ADDR == OFF_BYTE_BUFFER;
  assign dr_clear  = sr1_armed && (rd_dr || wr_dr);

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= SCL_IN;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= SDA_IN;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // ==========================================================
  // bus events
  logic start_det, stop_det, scl_rise, scl_fall, misplaced, ev_fall7, ev_end;
  logic own_hit, gc_hit, arb_ev, bd_set, nack_ev, stretch, m_sent_start, m_stop_done;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det  = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign misplaced = pe && (start_det || stop_det) && active && bit_cnt != 4'h0;
  assign ev_fall7  = scl_fall && active && bit_cnt == LAST_DATA_BIT;
  assign ev_end    = scl_fall && active && bit_cnt == ACK_BIT_INDEX;
  // bit 0 of own address is ignored and 01h never matches
  assign own_hit   = s_addr && shreg[7:1] == own_low[7:1] && shreg[7:1] != 7'h00
                     && shreg != IGNORED_ADDR;
  assign gc_hit    = s_addr && shreg == GENERAL_CALL_ADDR && gc_en;
  // arbitration only on data bits, never on the acknowledge bit
  assign arb_ev    = scl_rise && active && master_role && is_tx && bit_cnt < ACK_BIT_INDEX
                     && shreg[7] && !sda_s;
  assign bd_set    = (ev_end && is_tx && !nack_seen && !(m_addr && shreg[0]))
                     || (ev_end && !is_tx && !s_addr);
  assign nack_ev   = ev_end && is_tx && nack_seen;
  assign stretch   = byte_done || addr_matched || start_sent;
  assign m_sent_start = mst == M_START && cnt == '0;
  assign m_stop_done  = mst == M_STOPB && scl_s && cnt == '0;

  // ==========================================================
  // control register
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      {pe, gc_en, start_req, ack_en, stop_req, interrupt_enable_bit} <= CONTROL_RST[5:0];
    end else if (wr_ctrl && !pe) begin
      pe <= WR_DATA[CTL_PE];
    end else if (wr_ctrl) begin
      pe        <= WR_DATA[CTL_PE];
      gc_en     <= WR_DATA[CTL_GENERAL_CALL_ENABLE];
      start_req <= WR_DATA[CTL_START];
      ack_en    <= WR_DATA[CTL_ACK];
      stop_req  <= WR_DATA[CTL_STOP];
      interrupt_enable_bit       <= WR_DATA[CTL_ITE];
    end else if (!pe) begin
      {gc_en, start_req, ack_en, interrupt_enable_bit} <= 4'h0;
    end else begin
      if (m_sent_start || arb_ev) begin
        start_req <= 1'b0;
      end
      if (m_stop_done) begin
        stop_req <= 1'b0;
      end
    end
  end

  // ==========================================================
  // configuration registers, kept across disable
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      clock_set <= CLOCK_SET_RST;
      own_low   <= OWN_LOW_RST;
      own_high  <= OWN_HIGH_RST;
    end else begin
      if (wr_clk) begin
        clock_set <= WR_DATA;
      end
      if (wr_own_lo) begin
        own_low <= WR_DATA;
      end
      if (wr_own_hi) begin
        own_high[OWN_A9] <= WR_DATA[OWN_A9];
        own_high[OWN_A8] <= WR_DATA[OWN_A8];
        if (!pe) begin
          own_high[OWN_FR_HI] <= WR_DATA[OWN_FR_HI];
          own_high[OWN_FR_LO] <= WR_DATA[OWN_FR_LO];
        end
      end
    end
  end

  // ==========================================================
  // data register: written by software, loaded from the bus
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      byte_buffer <= BYTE_BUFFER_RST;
    end else if (ev_fall7 && !is_tx && !s_addr) begin
      byte_buffer <= shreg;
    end else if (wr_dr) begin
      byte_buffer <= WR_DATA;
    end
  end

  // ==========================================================
  // status-one flags (set wins over clear, except busy and master_role where clear wins)
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sr1_armed <= 1'b0;
    end else if (rd_sr1) begin
      sr1_armed <= 1'b1;
    end else if (rd_dr || wr_dr || !pe) begin
      sr1_armed <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      busy <= 1'b0;
    end else if (misplaced || stop_det) begin
      busy <= 1'b0;
    end else if (start_det) begin
      busy <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      byte_done <= 1'b0;
    end else if (!pe) begin
      byte_done <= 1'b0;
    end else if (bd_set) begin
      byte_done <= 1'b1;
    end else if (dr_clear || misplaced || arb_ev) begin
      byte_done <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      addr_matched <= 1'b0;
    end else if (!pe) begin
      addr_matched <= 1'b0;
    end else if (ev_end && s_addr && slv_sel) begin
      // set once the acknowledge clock is through, so the stretch follows it
      addr_matched <= 1'b1;
    end else if (rd_sr1) begin
      addr_matched <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      master_role <= 1'b0;
    end else if (!pe || stop_det || arb_ev) begin
      master_role <= 1'b0;
    end else if (mst == M_IDLE && start_req && !busy) begin
      master_role <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      start_sent <= 1'b0;
    end else if (!pe) begin
      start_sent <= 1'b0;
    end else if (m_sent_start) begin
      start_sent <= 1'b1;
    end else if (sr1_armed && wr_dr) begin
      start_sent <= 1'b0;
    end
  end

  // ==========================================================
  // status-two flags
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      {ack_fail, stop_seen, arb_lost, bus_err} <= 4'h0;
    end else if (!pe) begin
      {ack_fail, stop_seen, arb_lost, bus_err} <= 4'h0;
    end else begin
      if (nack_ev) begin
        ack_fail <= 1'b1;
      end else if (rd_sr2) begin
        ack_fail <= 1'b0;
      end
      if (stop_det && !master_role && ack_en && slv_sel) begin
        stop_seen <= 1'b1;
      end else if (rd_sr2) begin
        stop_seen <= 1'b0;
      end
      if (arb_ev) begin
        arb_lost <= 1'b1;
      end else if (rd_sr2) begin
        arb_lost <= 1'b0;
      end
      if (misplaced) begin
        bus_err <= 1'b1;
      end else if (rd_sr2) begin
        bus_err <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      general_call_seen_flag <= 1'b0;
    end else if (!pe || stop_det) begin
      general_call_seen_flag <= 1'b0;
    end else if (ev_fall7 && gc_hit) begin
      general_call_seen_flag <= 1'b1;
    end
  end

  // ==========================================================
  // byte engine: shifts on SCL rise, steps on SCL fall
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      active    <= 1'b0;
      is_tx     <= 1'b0;
      s_addr    <= 1'b0;
      m_addr    <= 1'b0;
      ack_drive <= 1'b0;
      nack_seen <= 1'b0;
      slv_sel   <= 1'b0;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      start_fall <= 1'b0;
    end else if (!pe || misplaced || arb_ev || stop_det) begin
      // a bus error drops the transfer; the master resynchronises with stop or restart
      active    <= 1'b0;
      is_tx     <= 1'b0;
      s_addr    <= 1'b0;
      m_addr    <= 1'b0;
      ack_drive <= 1'b0;
      slv_sel   <= 1'b0;
      bit_cnt   <= 4'h0;
      start_fall <= 1'b0;
    end else if (start_det) begin
      active    <= 1'b1;
      is_tx     <= 1'b0;
      s_addr    <= !master_role;
      m_addr    <= 1'b0;
      ack_drive <= 1'b0;
      slv_sel   <= 1'b0;
      bit_cnt   <= 4'h0;
      start_fall <= 1'b1;
    end else if (wr_dr && bit_cnt == 4'h0 && (start_sent || is_tx)) begin
      shreg  <= WR_DATA;
      is_tx  <= 1'b1;
      m_addr <= start_sent;
    end else if (scl_rise && active) begin
      if (bit_cnt < ACK_BIT_INDEX) begin
        shreg <= {shreg[6:0], sda_s};
      end else begin
        nack_seen <= sda_s;
      end
    end else if (ev_fall7) begin
      bit_cnt <= ACK_BIT_INDEX;
      if (s_addr) begin
        active    <= own_hit || gc_hit;
        slv_sel   <= own_hit || gc_hit;
        ack_drive <= own_hit || gc_hit;
        is_tx     <= (own_hit || gc_hit) && shreg[0] && !gc_hit;
      end else begin
        ack_drive <= !is_tx && ack_en;
      end
    end else if (ev_end) begin
      bit_cnt   <= 4'h0;
      ack_drive <= 1'b0;
      s_addr    <= 1'b0;
      m_addr    <= 1'b0;
      if (m_addr && !nack_seen) begin
        is_tx <= !shreg[0];
      end
      if (nack_ev && !master_role) begin
        active <= 1'b0;
      end
    end else if (scl_fall && active && start_fall) begin
      // the clock fall that closes a start is not a data bit
      start_fall <= 1'b0;
    end else if (scl_fall && active) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // ==========================================================
  // bus clock generator for master mode
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mst <= M_IDLE;
      cnt <= '0;
    end else if (!pe || arb_ev) begin
      mst <= M_IDLE;
      cnt <= '0;
    end else if (cnt != '0 && ((mst != M_HIGH && mst != M_STOPB && mst != M_RSB) || scl_s)) begin
      cnt <= cnt - CNT_W'(1);
    end else if (cnt == '0) begin
      cnt <= half_period(clock_set);
      case (mst)
        M_IDLE: begin
          if (start_req && !busy) begin
            mst <= M_START;
          end
        end
        M_START: begin
          mst <= M_LOW;
        end
        M_LOW: begin
          if (stretch || ack_fail) begin
            mst <= M_LOW;
          end else if (bit_cnt == 4'h0 && stop_req) begin
            mst <= M_STOPA;
          end else if (bit_cnt == 4'h0 && start_req) begin
            mst <= M_RSA;
          end else if (active) begin
            mst <= M_HIGH;
          end
        end
        M_HIGH: begin
          if (scl_s) begin
            mst <= M_LOW;
          end
        end
        M_STOPA: begin
          mst <= M_STOPB;
        end
        M_STOPB: begin
          if (scl_s) begin
            mst <= M_IDLE;
          end
        end
        M_RSA: begin
          mst <= M_RSB;
        end
        M_RSB: begin
          if (scl_s) begin
            mst <= M_START;
          end
        end
        default: begin
          mst <= M_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // pin drive
  always_comb begin
    next_scl_low = 1'b0;
    next_sda_low = 1'b0;
    case (mst)
      M_START: next_sda_low = 1'b1;
      M_LOW:   next_scl_low = 1'b1;
      M_STOPA: begin
        next_scl_low = 1'b1;
        next_sda_low = 1'b1;
      end
      M_STOPB: next_sda_low = 1'b1;
      M_RSA:   next_scl_low = 1'b1;
      default: next_scl_low = 1'b0;
    endcase
    if (stretch && !scl_s) begin
      next_scl_low = 1'b1;
    end
    if (active && bit_cnt < ACK_BIT_INDEX && is_tx && !shreg[7]) begin
      next_sda_low = 1'b1;
    end
    if (active && bit_cnt == ACK_BIT_INDEX && ack_drive) begin
      next_sda_low = 1'b1;
    end
    if (!pe) begin
      next_scl_low = 1'b0;
      next_sda_low = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      SCL_OUT <= 1'b0;
      SCL_OE  <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE  <= 1'b0;
    end else begin
      SCL_OUT <= 1'b0;
      SCL_OE  <= next_scl_low;
      SDA_OUT <= 1'b0;
      SDA_OE  <= next_sda_low;
    end
  end

  // ==========================================================
  // interrupt and read-back
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= interrupt_enable_bit && (byte_done || addr_matched || start_sent || ack_fail
                     || stop_seen || arb_lost || bus_err);
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RD_DATA <= 8'h00;
    end else if (RD_STB) begin
      case (ADDR)
        OFF_CONTROL:     RD_DATA <= {2'b00, pe, gc_en, start_req, ack_en, stop_req, interrupt_enable_bit};
        OFF_STATUS_ONE:  RD_DATA <= {stretch || ack_fail || stop_seen || arb_lost || bus_err,
                                     1'b0, is_tx && byte_done, busy, byte_done,
                                     addr_matched, master_role, start_sent};
        OFF_STATUS_TWO:  RD_DATA <= {3'b000, ack_fail, stop_seen, arb_lost, bus_err,
                                     general_call_seen_flag};
        OFF_CLOCK_SET:   RD_DATA <= clock_set;
        OFF_OWN_LOW:     RD_DATA <= own_low;
        OFF_OWN_HIGH:    RD_DATA <= {own_high[OWN_FR_HI], own_high[OWN_FR_LO], 3'b000,
                                     own_high[OWN_A9], own_high[OWN_A8], 1'b0};
        OFF_BYTE_BUFFER: RD_DATA <= byte_buffer;
        default:         RD_DATA <= 8'h00;
      endcase
    end else begin
      RD_DATA <= 8'h00;
    end
  end

endmodule

// File: i2cr_top_tb.sv
// Purpose: self-checking bench of i2cr_top
// Assumes: 100 MHz REF_CLK, slave-side traffic
// Notes:   model master drives the far side
module i2cr_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import i2cr_pkg::*;
  logic       REF_CLK, RST, WR_STB, RD_STB, SCL_OE, SDA_OE, IRQ, m_scl, m_sda;
  logic [2:0] ADDR;
  logic [7:0] WR_DATA, RD_DATA;
  int         fail_count = 0;
  int         check_count = 0;
  wire        scl = !(SCL_OE || m_scl);
  wire        sda = !(SDA_OE || m_sda);
  i2cr_top u_i2cr_top (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .SCL_IN(scl), .SCL_OUT(),
    .SCL_OE(SCL_OE), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(SDA_OE), .IRQ(IRQ));
  i2cr_bus_master u_i2cr_bus_master (.clk(REF_CLK), .scl(scl), .sda(sda),
    .scl_low(m_scl), .sda_low(m_sda));
  task automatic close_out();
    fail_count += u_i2cr_bus_master.stalls;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    {WR_STB, ADDR, WR_DATA} <= {1'b1, a, d};
    @(posedge REF_CLK);
    WR_STB <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge REF_CLK);
    {RD_STB, ADDR} <= {1'b1, a};
    @(posedge REF_CLK);
    RD_STB <= 1'b0;
    #1 d = RD_DATA;
  endtask
  task automatic test_regs();
    logic [7:0] v;
    logic [7:0] exp [2:7] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00};
    for (int i = 2; i < 8; i++) begin
      rd(3'(i), v);
      chk("reset value", exp[i], v);
    end
    wr(OFF_STATUS_TWO, 8'hFF);
    rd(OFF_STATUS_TWO, v);
    chk("status two", 8'h00, v);
    wr(OFF_OWN_HIGH, 8'hC6);
    wr(OFF_CLOCK_SET, 8'h85);
    wr(OFF_CONTROL, 8'h20);
    wr(OFF_OWN_HIGH, 8'h00);
    rd(OFF_OWN_HIGH, v);
    chk("own high", 8'hC0, v);
    wr(OFF_CONTROL, 8'h00);
    rd(OFF_CLOCK_SET, v);
    chk("clock setting", 8'h85, v);
  endtask
  task automatic test_addr(input logic [7:0] own, input logic [7:0] sent, input logic ack_exp);
    logic       ack;
    logic [7:0] v;
    wr(OFF_OWN_LOW, own);
    wr(OFF_CONTROL, 8'h20);
    wr(OFF_CONTROL, 8'h25);
    u_i2cr_bus_master.start();
    rd(OFF_STATUS_ONE, v);
    chk("bus active", 8'h10, v & 8'h10);
    u_i2cr_bus_master.send_byte(sent, ack);
    chk("address ack", {7'h0, ack_exp}, {7'h0, ack});
    if (ack_exp) begin
      chk("irq", 8'h01, {7'h0, IRQ});
      u_i2cr_bus_master.let_go();
      repeat (50) @(posedge REF_CLK);
      chk("clock held", 8'h00, {7'h0, scl});
      rd(OFF_STATUS_ONE, v);
      chk("matched", 8'h14, v & 8'h17);
      for (int n = 0; n < 100 && scl !== 1'b1; n++) @(posedge REF_CLK);
      chk("clock freed", 8'h01, {7'h0, scl});
      if (scl !== 1'b1) close_out();
    end
    // after a clocked bit this stop is misplaced
    u_i2cr_bus_master.stop();
    rd(OFF_STATUS_ONE, v);
    chk("bus idle", 8'h00, v & 8'h10);
    rd(OFF_STATUS_TWO, v);
    chk("bus error", {6'h0, ack_exp, 1'b0}, v & 8'h02);
    rd(OFF_STATUS_TWO, v);
    chk("bus error cleared", 8'h00, v & 8'h02);
    wr(OFF_CONTROL, 8'h00);
  endtask
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  initial begin
    repeat (100000) @(posedge REF_CLK);
    fail_count++;
    close_out();
  end
  initial begin
    {RST, WR_STB, RD_STB, ADDR, WR_DATA} = {3'b100, 3'h0, 8'h00};
    repeat (3) @(posedge REF_CLK);
    RST <= 1'b0;
    test_regs();
    test_addr(8'h66, 8'h66, 1'b1);
    test_addr(8'h00, 8'h01, 1'b0);
    test_addr(8'h66, 8'h64, 1'b0);
    close_out();
  end
endmodule
